// ### hw/wsc_defines.vh
`ifndef WSC_DEFINES_VH
`define WSC_DEFINES_VH
// ----------------------------------------
// Configuration encodings
// ----------------------------------------
`define WSC_OSC_LF 2'h0
`define WSC_OSC_RC 2'h1
`define WSC_OSC_XT 2'h2
`define WSC_OSC_EC 2'h3
`define WSC_PS_TIMER 2'h0
`define WSC_PS_64 2'h1
`define WSC_PS_256 2'h2
`define WSC_PS_1 2'h3
`define WSC_PM_PROTECT 3'h0
// ----------------------------------------
// Register map
// ----------------------------------------
`define WSC_ADDR_CPU_STATUS 8'h06
`define WSC_ADDR_WAKE_CTRL 8'h20
`define WSC_ADDR_WAKE_STAT 8'h21
`define WSC_ST_STKAV 5
`define WSC_ST_GLOBAL_INT_DISABLE 4
`define WSC_ST_TO 3
`define WSC_ST_PD 2
`define WSC_ST_POR 1
`define WSC_ST_BOR 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define WSC_WDT_BASE_MS 12
`define WSC_RC_TICK_NS 1000
`define WSC_WDT_BASE_TICKS ((`WSC_WDT_BASE_MS * 1000000) / `WSC_RC_TICK_NS)
`define WSC_TIMER_TOSC 65536
`define WSC_OST_TOSC 1024
`define WSC_TOSC_NS 10
`define WSC_OST_CYCLES ((`WSC_OST_TOSC * `WSC_TOSC_NS + 9) / 10)
`define WSC_POWERUP_TIMER_MS 96
`define WSC_POWERUP_TIMER_CYCLES ((`WSC_POWERUP_TIMER_MS * 1000000) / `WSC_TOSC_NS)
`endif

// ### hw/wsc_rc_osc.v
`timescale 1ns/1ps
// ----------------------------------------
// Free-running watchdog tick source
// ----------------------------------------
module wsc_rc_osc #(
    parameter TICK_CYCLES = 100
) (
    input wire clock,
    input wire nrst,
    output reg tick_q
);
    reg [15:0] cnt_q;
    always @(posedge clock) begin
        if (!nrst) begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (cnt_q == TICK_CYCLES[15:0] - 16'h0001) begin
            cnt_q <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end
endmodule // wsc_rc_osc

// ### hw/wsc_watchdog_sleep.v
`timescale 1ns/1ps
`include "wsc_defines.vh"
// Functional notes
// RULE_01: Four oscillator modes chosen by a two-bit select field.
// RULE_02: Watchdog counts from its own free-running tick, also during sleep.
// RULE_03: Enabled watchdog overflow in normal run causes full device reset.
// RULE_04: Postscale select 00 disables watchdog reset permanently.
// RULE_05: Base period 12 ms, scaled by postscale up to about 3 s.
// RULE_06: Counter and postscaler clear on reset, sleep, clear instruction, interrupt wake.
// RULE_07: Counting starts on the first edge after leaving reset.
// RULE_08: Any watchdog time-out clears the active-low time-out flag.
// RULE_09: Power-up delay reuses the watchdog counter and postscaler; the code reuses only the counter, not the postscaler.
// RULE_10: Timer mode overflows after 65536 clocks, clears flag, no reset.
// RULE_11: Timer mode clear instruction sets flag; counter not software visible.
// RULE_12: Timer mode counter halts during sleep.
// RULE_13: Sleep entry stops oscillator, clears power-down flag, sets time-out flag.
// RULE_14: Ports hold their output state during sleep.
// RULE_15: Watchdog reset never drives the master clear pin.
// RULE_16: Sleep ends on reset sources or enabled wake interrupts.
// RULE_17: Only clockless peripherals may wake; others masked in sleep.
// RULE_18: Reset wake resets the device; interrupt wake resumes execution.
// RULE_19: Interrupt wake needs enable, ignores global disable; vector if enabled.
// RULE_20: Pending enabled interrupt at sleep wakes at once, flags as sleep.
// RULE_21: Watchdog counter clears on every wake from sleep.
// RULE_22: Crystal modes hold reset 1024 oscillator periods on wake; the code skips the hold on reset wake when por_n_q is 1.
// RULE_23: Code-protected mode blocks external-code program memory access.
// RULE_24: Postscale field: 11 is 1, 10 is 256, 01 is 64, 00 timer.
// RULE_25: Oscillator field: 11 external, 10 crystal, 01 RC, 00 low-freq.
// RULE_26: Configuration fields are static inputs from nonvolatile storage.
module wsc_watchdog_sleep #(
    parameter WDT_BASE_TICKS = `WSC_WDT_BASE_TICKS,
    parameter RC_TICK_CYCLES = `WSC_RC_TICK_NS / `WSC_TOSC_NS,
    parameter TIMER_CYCLES = `WSC_TIMER_TOSC,
    parameter OST_CYCLES = `WSC_OST_CYCLES,
    parameter POWERUP_TIMER_CYCLES = `WSC_POWERUP_TIMER_CYCLES
) (
    input wire clock,
    input wire nrst,
    input wire [1:0] osc_select,
    input wire [1:0] watchdog_postscale_select,
    input wire [2:0] processor_mode_select,
    input wire por_event,
    input wire bor_event,
    input wire master_clear_pin,
    input wire sleep_instr,
    input wire watchdog_clear_instr,
    input wire [7:0] int_enable,
    input wire [7:0] int_flag,
    input wire [7:0] int_clockless,
    input wire [7:0] port_out_in,
    input wire [7:0] port_oe_in,
    input wire fetch_external,
    input wire pm_access_req,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg device_reset,
    output reg asleep,
    output reg osc_drive_en,
    output reg resume_exec,
    output reg take_vector,
    output reg [7:0] port_out,
    output reg [7:0] port_oe,
    output reg pm_access_grant,
    output reg master_clear_drive_oe,
    output reg [7:0] periph_int_mask
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [8:0] post_len;
        input [1:0] sel;
        begin
            case (sel)
                `WSC_PS_1: post_len = 9'h001;
                `WSC_PS_64: post_len = 9'h040;
                `WSC_PS_256: post_len = 9'h100;
                default: post_len = 9'h001;
            endcase
        end
    endfunction
    function is_crystal;
        input [1:0] sel;
        begin
            is_crystal = (sel == `WSC_OSC_XT) || (sel == `WSC_OSC_LF);
        end
    endfunction

    localparam ST_RESET = 3'h0;
    localparam ST_POWERUP_TIMER = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_SLEEP = 3'h3;
    localparam ST_OST = 3'h4;
    localparam ST_WAKE_OST = 3'h5;

    // ----------------------------------------
    // Synchronisers and configuration capture
    // ----------------------------------------
    reg mclr_s1_q, mclr_s2_q;
    reg por_s1_q, por_s2_q, bor_s1_q, bor_s2_q;
    reg [1:0] osc_q, ps_q;
    reg [2:0] pm_q;
    always @(posedge clock) begin
        if (!nrst) begin
            mclr_s1_q <= 1'b1;
            mclr_s2_q <= 1'b1;
            por_s1_q <= 1'b0;
            por_s2_q <= 1'b0;
            bor_s1_q <= 1'b0;
            bor_s2_q <= 1'b0;
        end else begin
            mclr_s1_q <= master_clear_pin;
            mclr_s2_q <= mclr_s1_q;
            por_s1_q <= por_event;
            por_s2_q <= por_s1_q;
            bor_s1_q <= bor_event;
            bor_s2_q <= bor_s1_q;
        end
    end
    always @(posedge clock) begin
        osc_q <= osc_select; // see RULE_01 see RULE_25 see RULE_26
        ps_q <= watchdog_postscale_select; // see RULE_24 see RULE_26
        pm_q <= processor_mode_select; // see RULE_26
    end

    // ----------------------------------------
    // State and counters
    // ----------------------------------------
    wire rc_tick;
    wsc_rc_osc #(.TICK_CYCLES(RC_TICK_CYCLES)) u_rc (
        .clock(clock),
        .nrst(nrst),
        .tick_q(rc_tick)
    ); // see RULE_02

    reg [2:0] state_q, state_d;
    reg [23:0] wdt_cnt_q, wdt_cnt_d;
    reg [8:0] post_cnt_q, post_cnt_d;
    reg [23:0] hold_cnt_q, hold_cnt_d;
    reg to_n_q, to_n_d, pd_n_q, pd_n_d, global_int_disable_q, global_int_disable_d;
    reg por_n_q, por_n_d, bor_n_q, bor_n_d;
    reg [7:0] wake_cause_q, wake_cause_d;
    reg [7:0] port_out_d, port_oe_d;
    reg pending_vec_q, pending_vec_d;

    wire wdt_on = (ps_q != `WSC_PS_TIMER); // see RULE_04
    wire [7:0] wake_src = int_enable & int_flag & int_clockless; // see RULE_17 see RULE_19
    wire int_wake = |wake_src;
    wire ext_reset = !mclr_s2_q || por_s2_q || bor_s2_q;
    wire wdt_last = (wdt_cnt_q == WDT_BASE_TICKS[23:0] - 24'h000001);
    wire post_last = (post_cnt_q == post_len(ps_q) - 9'h001);
    wire wdt_ovf = wdt_on && rc_tick && wdt_last && post_last; // see RULE_05
    wire tmr_ovf = !wdt_on && (wdt_cnt_q == TIMER_CYCLES[23:0] - 24'h000001); // see RULE_10

    always @* begin
        state_d = state_q;
        wdt_cnt_d = wdt_cnt_q;
        post_cnt_d = post_cnt_q;
        hold_cnt_d = hold_cnt_q;
        to_n_d = to_n_q;
        pd_n_d = pd_n_q;
        global_int_disable_d = global_int_disable_q;
        por_n_d = por_n_q;
        bor_n_d = bor_n_q;
        wake_cause_d = wake_cause_q;
        port_out_d = port_out;
        port_oe_d = port_oe;
        pending_vec_d = 1'b0;
        if (reg_wr && reg_addr == `WSC_ADDR_CPU_STATUS) begin
            global_int_disable_d = reg_wdata[`WSC_ST_GLOBAL_INT_DISABLE];
            por_n_d = reg_wdata[`WSC_ST_POR] | por_n_q;
            bor_n_d = reg_wdata[`WSC_ST_BOR] | bor_n_q;
        end
        // Counting during run, and during sleep in watchdog mode; timer mode counts clocks, watchdog mode RC ticks
        if (state_q == ST_RUN || (state_q == ST_SLEEP && wdt_on)) begin
            if (wdt_on) begin
                if (rc_tick) begin // see RULE_02 see RULE_07
                    if (wdt_last) begin
                        wdt_cnt_d = 24'h000000;
                        post_cnt_d = post_last ? 9'h000 : post_cnt_q + 9'h001;
                    end else begin
                        wdt_cnt_d = wdt_cnt_q + 24'h000001;
                    end
                end
            end else begin
                wdt_cnt_d = tmr_ovf ? 24'h000000 : wdt_cnt_q + 24'h000001; // see RULE_12
                if (tmr_ovf) begin
                    to_n_d = 1'b0; // see RULE_10
                end
            end
        end
        case (state_q)
            ST_RESET: begin
                wdt_cnt_d = 24'h000000; // see RULE_06
                post_cnt_d = 9'h000;
                hold_cnt_d = 24'h000000;
                port_out_d = 8'h00;
                port_oe_d = 8'h00;
                if (!ext_reset) begin
                    state_d = por_n_q ? ST_RUN : ST_POWERUP_TIMER;
                end
            end
            ST_POWERUP_TIMER: begin
                // Power-up delay on the shared watchdog counter
                wdt_cnt_d = wdt_cnt_q + 24'h000001; // see RULE_09
                if (wdt_cnt_q == POWERUP_TIMER_CYCLES[23:0] - 24'h000001) begin
                    wdt_cnt_d = 24'h000000;
                    state_d = is_crystal(osc_q) ? ST_OST : ST_RUN;
                end
            end
            ST_RUN: begin
                port_out_d = port_out_in;
                port_oe_d = port_oe_in;
                if (watchdog_clear_instr) begin
                    wdt_cnt_d = 24'h000000; // see RULE_06
                    post_cnt_d = 9'h000;
                    if (!wdt_on) begin
                        to_n_d = 1'b1; // see RULE_11
                    end
                end else if (sleep_instr) begin
                    wdt_cnt_d = 24'h000000; // see RULE_06
                    post_cnt_d = 9'h000;
                    pd_n_d = 1'b0; // see RULE_13
                    to_n_d = 1'b1;
                    state_d = int_wake ? ST_RUN : ST_SLEEP; // see RULE_20
                    pending_vec_d = int_wake && !global_int_disable_q;
                end else if (wdt_ovf) begin
                    to_n_d = 1'b0; // see RULE_08
                    state_d = ST_RESET; // see RULE_03
                end
            end
            ST_SLEEP: begin
                // Port state frozen; no update from the core
                if (wdt_ovf) begin
                    to_n_d = 1'b0; // see RULE_08
                    wake_cause_d = 8'h01;
                    wdt_cnt_d = 24'h000000; // see RULE_21
                    post_cnt_d = 9'h000;
                    state_d = ST_RESET; // see RULE_18
                end else if (int_wake) begin // see RULE_16
                    wake_cause_d = 8'h02;
                    wdt_cnt_d = 24'h000000; // see RULE_06 see RULE_21
                    post_cnt_d = 9'h000;
                    hold_cnt_d = 24'h000000;
                    state_d = is_crystal(osc_q) ? ST_WAKE_OST : ST_RUN; // see RULE_22
                    pending_vec_d = !is_crystal(osc_q) && !global_int_disable_q;
                end
            end
            ST_OST, ST_WAKE_OST: begin
                hold_cnt_d = hold_cnt_q + 24'h000001; // see RULE_22
                if (hold_cnt_q == OST_CYCLES[23:0] - 24'h000001) begin
                    state_d = ST_RUN;
                    pending_vec_d = (state_q == ST_WAKE_OST) && !global_int_disable_q; // see RULE_19
                end
            end
            default: state_d = ST_RESET;
        endcase
        if (ext_reset) begin
            state_d = ST_RESET; // see RULE_16 see RULE_18
            if (state_q == ST_SLEEP) begin
                wake_cause_d = 8'h04;
            end
            if (por_s2_q) begin
                por_n_d = 1'b0;
                pd_n_d = 1'b1;
                to_n_d = 1'b1;
            end
            if (bor_s2_q) begin
                bor_n_d = 1'b0;
            end
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            state_q <= ST_RESET;
            wdt_cnt_q <= 24'h000000;
            post_cnt_q <= 9'h000;
            hold_cnt_q <= 24'h000000;
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
            global_int_disable_q <= 1'b1;
            por_n_q <= 1'b0;
            bor_n_q <= 1'b0;
            wake_cause_q <= 8'h00;
            pending_vec_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wdt_cnt_q <= wdt_cnt_d;
            post_cnt_q <= post_cnt_d;
            hold_cnt_q <= hold_cnt_d;
            to_n_q <= to_n_d;
            pd_n_q <= pd_n_d;
            global_int_disable_q <= global_int_disable_d;
            por_n_q <= por_n_d;
            bor_n_q <= bor_n_d;
            wake_cause_q <= wake_cause_d;
            pending_vec_q <= pending_vec_d;
        end
    end

    // ----------------------------------------
    // Outputs and register reads
    // ----------------------------------------
    always @(posedge clock) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
            device_reset <= 1'b1;
            asleep <= 1'b0;
            osc_drive_en <= 1'b1;
            resume_exec <= 1'b0;
            take_vector <= 1'b0;
            port_out <= 8'h00;
            port_oe <= 8'h00;
            pm_access_grant <= 1'b0;
            master_clear_drive_oe <= 1'b0;
            periph_int_mask <= 8'hFF;
        end else begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `WSC_ADDR_CPU_STATUS: reg_rdata <= {2'h0, 1'b1, global_int_disable_q, to_n_q, pd_n_q, por_n_q, bor_n_q};
                    `WSC_ADDR_WAKE_CTRL: reg_rdata <= {1'b0, pm_q, ps_q, osc_q};
                    `WSC_ADDR_WAKE_STAT: reg_rdata <= wake_cause_q;
                    default: reg_rdata <= 8'h00;
                endcase
            end
            device_reset <= (state_d == ST_RESET) || (state_d == ST_POWERUP_TIMER) || (state_d == ST_OST)
                || (state_d == ST_WAKE_OST);
            asleep <= (state_d == ST_SLEEP);
            osc_drive_en <= (state_d != ST_SLEEP); // see RULE_13
            resume_exec <= (state_q == ST_SLEEP || state_q == ST_WAKE_OST) && state_d == ST_RUN; // see RULE_18
            take_vector <= pending_vec_q; // see RULE_19
            port_out <= port_out_d; // see RULE_14
            port_oe <= port_oe_d;
            pm_access_grant <= pm_access_req && !(pm_q == `WSC_PM_PROTECT && fetch_external); // see RULE_23
            master_clear_drive_oe <= 1'b0; // see RULE_15
            periph_int_mask <= (state_d == ST_SLEEP) ? int_clockless : 8'hFF; // see RULE_17
        end
    end
endmodule // wsc_watchdog_sleep

// ### test/wsc_asserts.sv
`timescale 1ns/1ps
`include "wsc_defines.vh"
module wsc_asserts (
    input wire clock,
    input wire nrst,
    input wire [1:0] osc_select,
    input wire [1:0] watchdog_postscale_select,
    input wire [2:0] processor_mode_select,
    input wire por_event,
    input wire bor_event,
    input wire master_clear_pin,
    input wire sleep_instr,
    input wire [7:0] int_enable,
    input wire [7:0] int_flag,
    input wire [7:0] int_clockless,
    input wire fetch_external,
    input wire pm_access_req,
    input wire device_reset,
    input wire asleep,
    input wire osc_drive_en,
    input wire [7:0] port_out,
    input wire [7:0] port_oe,
    input wire pm_access_grant,
    input wire master_clear_drive_oe,
    input wire [7:0] periph_int_mask
);
default clocking cb @(posedge clock); endclocking
default disable iff (!nrst);
wire quiet = master_clear_pin & ~por_event & ~bor_event;
wire [7:0] pend = int_enable & int_flag & int_clockless;
// ----------------------------------------
// Properties
// ----------------------------------------
property p_mclr_quiet;
    master_clear_drive_oe == 1'b0;
endproperty
a_mclr_quiet: assert property (p_mclr_quiet) else $error("master clear driven");
property p_grant;
    $past(nrst) |-> pm_access_grant == $past(pm_access_req
        && !(processor_mode_select == `WSC_PM_PROTECT && fetch_external));
endproperty
a_grant: assert property (p_grant) else $error("program memory grant wrong");
property p_osc_off;
    asleep |-> !osc_drive_en;
endproperty
a_osc_off: assert property (p_osc_off) else $error("oscillator on in sleep");
property p_port_hold;
    asleep && $past(asleep) |-> $stable(port_out) && $stable(port_oe);
endproperty
a_port_hold: assert property (p_port_hold) else $error("port changed in sleep");
property p_mask;
    asleep && $past(asleep) |-> periph_int_mask == $past(int_clockless);
endproperty
a_mask: assert property (p_mask) else $error("sleep interrupt mask wrong");
property p_sleep_entry;
    sleep_instr && !asleep && !device_reset && pend == 8'h00 |=> asleep;
endproperty
a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
property p_pending;
    sleep_instr && !asleep && !device_reset && pend != 8'h00 |=> !asleep [*2];
endproperty
a_pending: assert property (p_pending) else $error("slept with pending wake");
property p_timer_quiet;
    watchdog_postscale_select == `WSC_PS_TIMER && osc_select[0] && !asleep && !device_reset
        && quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3) |=> !device_reset;
endproperty
a_timer_quiet: assert property (p_timer_quiet) else $error("timer mode reset");
endmodule // wsc_asserts

bind wsc_watchdog_sleep wsc_asserts wsc_asserts_i (.*);

// ### test/testbench.sv
`timescale 1ns/1ps
`include "wsc_defines.vh"
module testbench;
// ----------------------------------------
// Signals and design
// ----------------------------------------
logic clock, nrst, por_event, bor_event, master_clear_pin, sleep_instr, watchdog_clear_instr;
logic fetch_external, pm_access_req, reg_wr, reg_rd;
logic [1:0] osc_select, watchdog_postscale_select;
logic [2:0] processor_mode_select;
logic [7:0] int_enable, int_flag, int_clockless, port_out_in, port_oe_in, reg_addr, reg_wdata, st;
wire [7:0] reg_rdata, port_out, port_oe, periph_int_mask;
wire device_reset, asleep, osc_drive_en, resume_exec, take_vector, pm_access_grant, master_clear_drive_oe;
int fails = 0;
int n_tests = 0;
int n;
int r0;
int rise = 0;
// Postscale code and multiplier
int rows [3][2] = '{'{3, 1}, '{1, 64}, '{2, 256}};
wsc_watchdog_sleep #(.WDT_BASE_TICKS(4), .RC_TICK_CYCLES(2), .TIMER_CYCLES(16), .OST_CYCLES(8),
    .POWERUP_TIMER_CYCLES(8)) wsc_watchdog_sleep_i (.*);
initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
end
always @(posedge device_reset) rise++;
initial begin
    #200000;
    fails++;
    stop_test();
end
// ----------------------------------------
// Tasks
// ----------------------------------------
task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
        fails++;
        $display("ERROR %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic chk_rng(string what, int lo, int hi);
    n_tests++;
    if (n < lo || n > hi) begin
        fails++;
        $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, n);
    end
endtask
task automatic cyc(int k);
    repeat (k) @(posedge clock);
endtask
task automatic wait_on(int sel, int lim);
    n = 0;
    while (n < lim && !((sel == 0 && device_reset === 1'b1) || (sel == 1 && device_reset === 1'b0)
        || (sel == 2 && resume_exec === 1'b1))) begin
        @(posedge clock);
        n++;
    end
    if (n >= lim) begin
        fails++;
        $display("ERROR wait_on %0d expected event seen none", sel);
    end
endtask
task automatic rd_reg(logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    st = reg_rdata;
endtask
task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
endtask
task automatic pulse(bit clr);
    @(posedge clock);
    if (clr) watchdog_clear_instr <= 1'b1;
    else sleep_instr <= 1'b1;
    @(posedge clock);
    watchdog_clear_instr <= 1'b0;
    sleep_instr <= 1'b0;
endtask
task automatic restart(logic [1:0] o, logic [1:0] p);
    @(posedge clock);
    nrst <= 1'b0;
    osc_select <= o;
    watchdog_postscale_select <= p;
    cyc(4);
    nrst <= 1'b1;
    wait_on(1, 200);
    chk_rng("boot", 1, 199);
    r0 = rise;
endtask
task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
    nrst = 1'b0;
    {por_event, bor_event, sleep_instr, watchdog_clear_instr, fetch_external, pm_access_req} = 6'h00;
    {reg_wr, reg_rd} = 2'h0;
    master_clear_pin = 1'b1;
    osc_select = `WSC_OSC_RC;
    watchdog_postscale_select = `WSC_PS_256;
    processor_mode_select = `WSC_PM_PROTECT;
    {int_enable, int_flag, port_out_in, port_oe_in, reg_addr, reg_wdata} = 48'h0;
    int_clockless = 8'h0C;
    cyc(4);
    chk("reset_outputs", 8'h06, {5'h0, device_reset, osc_drive_en, asleep});
    restart(`WSC_OSC_RC, `WSC_PS_256);
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("status_reset", 8'h3C, st & 8'hFC);
    rd_reg(`WSC_ADDR_WAKE_CTRL);
    chk("config_read", 8'h09, st);
    rd_reg(8'h7F);
    chk("unmapped_read", 8'h00, st);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
        restart(`WSC_OSC_RC, 2'(rows[i][0]));
        wait_on(0, 8 * rows[i][1] + 40);
        chk_rng("wdt_period", 8 * rows[i][1] - 4, 8 * rows[i][1] + 12);
        wait_on(1, 200);
        rd_reg(`WSC_ADDR_CPU_STATUS);
        chk("wdt_flags", 8'h04, st & 8'h0C);
    end
    restart(`WSC_OSC_RC, `WSC_PS_1);
    repeat (15) begin
        cyc(2);
        pulse(1'b1);
    end
    n = rise - r0;
    chk_rng("clear_holds_off", 0, 0);
    $display("test watchdog done");
    restart(`WSC_OSC_RC, `WSC_PS_TIMER);
    cyc(40);
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("timer_overflow", 8'h04, st & 8'h0C);
    pulse(1'b1);
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("timer_clear", 8'h0C, st & 8'h0C);
    pulse(1'b0);
    cyc(40);
    int_enable <= 8'h04;
    int_flag <= 8'h04;
    wait_on(2, 20);
    int_flag <= 8'h00;
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("timer_sleep_halt", 8'h08, st & 8'h0C);
    n = rise - r0;
    chk_rng("timer_no_reset", 0, 0);
    $display("test timer done");
    restart(`WSC_OSC_RC, `WSC_PS_256);
    for (int g = 0; g < 2; g++) begin
        wr_reg(`WSC_ADDR_CPU_STATUS, g ? 8'h10 : 8'h00);
        port_out_in <= 8'hA5;
        port_oe_in <= 8'h0F;
        pulse(1'b0);
        cyc(1);
        chk("sleep_entry", 8'h02, {6'h0, asleep, osc_drive_en});
        port_out_in <= 8'h5A;
        int_enable <= 8'h05;
        int_flag <= 8'h01;
        rd_reg(`WSC_ADDR_CPU_STATUS);
        chk("sleep_flags", 8'h08, st & 8'h0C);
        chk("port_hold", 8'hA5, port_out);
        chk("late_source", 8'h01, {7'h0, asleep});
        int_flag <= 8'h05;
        wait_on(2, 20);
        chk_rng("int_wake", 1, 19);
        @(posedge clock);
        chk("vector", g ? 8'h00 : 8'h01, {7'h0, take_vector});
        int_flag <= 8'h00;
        rd_reg(`WSC_ADDR_WAKE_STAT);
        chk("wake_cause", 8'h02, st);
    end
    n = rise - r0;
    chk_rng("int_no_reset", 0, 0);
    int_flag <= 8'h04;
    pulse(1'b0);
    cyc(1);
    chk("pending_wake", 8'h00, {7'h0, asleep});
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("pending_flags", 8'h08, st & 8'h0C);
    int_flag <= 8'h00;
    $display("test sleep done");
    for (int o = 0; o < 4; o++) begin
        restart(2'(o), `WSC_PS_256);
        rd_reg(`WSC_ADDR_WAKE_CTRL);
        chk("osc_mode", 8'(o), {6'h0, st[1:0]});
        pulse(1'b0);
        cyc(2);
        int_flag <= 8'h04;
        wait_on(2, 60);
        if (o == 0 || o == 2) chk_rng("crystal_delay", 8, 30);
        else chk_rng("direct_wake", 1, 6);
        int_flag <= 8'h00;
    end
    restart(`WSC_OSC_RC, `WSC_PS_1);
    pulse(1'b0);
    wait_on(0, 40);
    chk_rng("sleep_wdt_wake", 1, 39);
    wait_on(1, 200);
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("sleep_wdt_flags", 8'h00, st & 8'h0C);
    restart(`WSC_OSC_RC, `WSC_PS_256);
    pulse(1'b0);
    cyc(2);
    master_clear_pin <= 1'b0;
    wait_on(0, 10);
    chk_rng("mclr_wake", 1, 9);
    master_clear_pin <= 1'b1;
    wait_on(1, 200);
    wr_reg(`WSC_ADDR_CPU_STATUS, 8'h03);
    bor_event <= 1'b1;
    wait_on(0, 10);
    bor_event <= 1'b0;
    wait_on(1, 20);
    rd_reg(`WSC_ADDR_CPU_STATUS);
    chk("bor_flags", 8'h02, st & 8'h03);
    $display("test wake sources done");
    for (int k = 0; k < 4; k++) begin
        fetch_external <= k[1];
        pm_access_req <= k[0];
        cyc(2);
        chk("pm_grant", {7'h0, k[0] & ~k[1]}, {7'h0, pm_access_grant});
    end
    processor_mode_select <= 3'h6;
    restart(`WSC_OSC_RC, `WSC_PS_256);
    chk("pm_open", 8'h01, {7'h0, pm_access_grant});
    $display("test code protect done");
    stop_test();
end
endmodule // testbench
